// ### hdl/wwd_map.svh
`ifndef WWD_MAP_SVH
`define WWD_MAP_SVH

// Register indices; byte address is four times the index
`define WWD_IDX_CTRL 2'd0
`define WWD_IDX_STAT 2'd1
`define WWD_IDX_KEY 2'd2

// Control field positions
`define WWD_PER_LSB 0
`define WWD_PER_MSB 3
`define WWD_WIN_LSB 4
`define WWD_WIN_MSB 7

// Status field positions
`define WWD_BUSY_BIT 0
`define WWD_LOCK_BIT 7

// Highest valid duration code, and the shift that turns a code into clocks
`define WWD_CODE_MAX 4'hb
`define WWD_CODE_SHIFT 4'd2
`define WWD_LEN_MAX 14'h2000

// Watchdog clock edges needed to carry a write or a clear across
`define WWD_SYNC_TICKS 2'd2

// CPU instructions during which a protected write may follow the key
`define WWD_CCP_INSTR 3'd4

// Reset values and unlock key
`define WWD_STAT_RST 8'h00
`define WWD_UNLOCK_KEY 8'h5a

`endif

// ### hdl/wwd_pkg.sv
package wwd_pkg;

	typedef enum logic [1:0] {
		WWD_OFF,
		WWD_FIRST,
		WWD_CLOSED,
		WWD_OPEN
	} wwd_mode_t;

	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic [7:0] ctrl;
		logic [7:0] act;
		logic lock;
		logic busy;
		logic [7:0] pend;
		logic [1:0] sync_cnt;
		logic clr_busy;
		logic [1:0] clr_cnt;
		logic [2:0] ccp_cnt;
		wwd_mode_t mode;
		logic [13:0] cnt;
		logic dbg;
		logic tick;
		logic rst;
	} wwd_state_t;

endpackage

// ### hdl/wwd_watchdog.sv
`include "wwd_map.svh"

// Contract
// - Nonzero period code enables the watchdog; zero keeps it disabled. Here a nonzero window code still starts an 8K-clock time-out on debug exit.
// - Normal mode requests system reset when time-out passes without clear.
// - Every accepted clear restarts the counter for a fresh time-out.
// - Eleven durations, 8 to 8K watchdog clocks, chosen by period code.
// - Window code zero means Normal mode; nonzero means Window mode.
// - Clear during the closed period requests a system reset.
// - Open period follows closed period; total is closed plus open.
// - After enabling Window mode or debug exit, first clear starts closed period.
// - Clear takes two to three watchdog clocks; here it lands on the second watchdog clock edge; clears meanwhile are ignored.
// - Counter advances on the roughly 1 kHz watchdog oscillator clock.
// - Period and window writes are synchronised; busy flag high meanwhile.
// - Debug halt stops watchdog operation and resets the counter.
// - Leaving debug in Window mode runs one Normal-style time-out first.
// - Keeps running in sleep and can reset even if main clock fails; here all logic runs on mclk_i.
// - While lock is one, control register changes are rejected.
// - Software may only set lock; clearing only possible in debug mode.
// - Control resets from fuse; fuse-enabled watchdog sets lock at boot.
// - Protected write needs unlock key then write within four instructions.
// - Unprotected writes to protected fields are acked but change nothing.
// - Period, window and lock are all under timed-write protection.
// - Window field bits 7:4; codes 1..B give 8..8K clocks closed.
// - Period field bits 3:0; codes 1..B give 8..8K clocks open.
// - Busy at status bit 0 cleared when sync done; lock at bit 7.
module wwd_watchdog
	import wwd_pkg::*;
#(
	parameter logic [7:0] UNLOCK_KEY = `WWD_UNLOCK_KEY
) (
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic watchdog_counter_clock_i,
	input wire logic watchdog_clear_instruction_i,
	input wire logic cpu_instr_i,
	input wire logic debug_halt_i,
	input wire logic [7:0] watchdog_config_fuse_i,
	output logic sys_reset_req_o
);

	// ****************************************************************
	// Duration decode
	// ****************************************************************

	// Reserved codes fall back to the longest span rather than hanging
	function automatic logic [13:0] span(input logic [3:0] code);
		logic [13:0] r;
		r = `WWD_LEN_MAX;
		if (code != 4'h0 && code <= `WWD_CODE_MAX) begin
			r = 14'h0001 << (code + `WWD_CODE_SHIFT);
		end
		return r;
	endfunction

	// Mode a freshly applied setting starts in
	function automatic wwd_mode_t start_mode(input logic [7:0] c);
		wwd_mode_t m;
		m = WWD_OFF;
		if (c[`WWD_PER_MSB:`WWD_PER_LSB] != 4'h0) begin
			m = (c[`WWD_WIN_MSB:`WWD_WIN_LSB] != 4'h0) ? WWD_FIRST :
				WWD_OPEN;
		end
		return m;
	endfunction

	// ****************************************************************
	// State
	// ****************************************************************

	wwd_state_t q;
	wwd_state_t d;
	wwd_state_t init;
	logic req;
	logic wr;
	logic tick;
	logic ccp_ok;
	logic clr_now;
	logic win_on;
	logic [13:0] plen;
	logic [13:0] wlen;
	logic [1:0] idx;
	logic ctrl_wr;

	// Request decode and watchdog clock edge detection
	assign req = wb_cyc_i & wb_stb_i;
	assign wr = req & wb_we_i & q.ack & wb_sel_i[0];
	assign idx = wb_adr_i[3:2];
	// Accepted control write; it must beat a sync finishing in the same cycle
	assign ctrl_wr = wr & (idx == `WWD_IDX_CTRL) & ccp_ok & ~q.lock;
	assign tick = watchdog_counter_clock_i & ~q.tick;
	assign ccp_ok = q.ccp_cnt != 3'd0;
	assign clr_now = tick & q.clr_busy &
		(q.clr_cnt == `WWD_SYNC_TICKS - 2'd1);
	assign win_on = q.act[`WWD_WIN_MSB:`WWD_WIN_LSB] != 4'h0;
	assign plen = span(q.act[`WWD_PER_MSB:`WWD_PER_LSB]);
	assign wlen = span(q.act[`WWD_WIN_MSB:`WWD_WIN_LSB]);

	// Fuse-loaded values taken while reset is held
	always_comb begin
		init = '0;
		init.ctrl = watchdog_config_fuse_i;
		init.act = watchdog_config_fuse_i;
		init.lock = watchdog_config_fuse_i[`WWD_PER_MSB:`WWD_PER_LSB] !=
			4'h0;
		init.mode = start_mode(watchdog_config_fuse_i);
		init.tick = watchdog_counter_clock_i;
		init.dbg = debug_halt_i;
	end

	// ****************************************************************
	// Next state
	// ****************************************************************

	always_comb begin
		d = q;
		d.ack = req & ~q.ack;
		d.rst = 1'b0;
		d.tick = watchdog_counter_clock_i;
		d.dbg = debug_halt_i;

		// Protection window closes after four executed instructions
		if (cpu_instr_i && ccp_ok) begin
			d.ccp_cnt = q.ccp_cnt - 3'd1;
		end

		// Read data is latched on the same edge that raises ack
		if (req && !q.ack) begin
			unique case (idx)
				`WWD_IDX_CTRL: d.rdata = {24'h0, q.ctrl};
				`WWD_IDX_STAT: begin
					d.rdata = {24'h0, `WWD_STAT_RST};
					d.rdata[`WWD_BUSY_BIT] = q.busy;
					d.rdata[`WWD_LOCK_BIT] = q.lock;
				end
				default: d.rdata = 32'h0;
			endcase
		end

		// Writes take effect on the edge where the master sees ack
		if (wr) begin
			unique case (idx)
				`WWD_IDX_KEY: begin
					if (wb_dat_i[7:0] == UNLOCK_KEY) begin
						d.ccp_cnt = `WWD_CCP_INSTR;
					end
				end
				`WWD_IDX_CTRL: begin
					// Locked or unprotected writes are acked and dropped
					if (ccp_ok && !q.lock) begin
						d.ctrl = wb_dat_i[7:0];
						d.pend = wb_dat_i[7:0];
						d.busy = 1'b1;
						d.sync_cnt = 2'd0;
						d.ccp_cnt = 3'd0;
					end
				end
				`WWD_IDX_STAT: begin
					if (ccp_ok) begin
						if (wb_dat_i[`WWD_LOCK_BIT]) begin
							d.lock = 1'b1;
						end else if (debug_halt_i) begin
							d.lock = 1'b0;
						end
						d.ccp_cnt = 3'd0;
					end
				end
				default: ;
			endcase
		end

		// A clear already crossing swallows any newer one
		if (watchdog_clear_instruction_i && !q.clr_busy &&
			!debug_halt_i) begin
			d.clr_busy = 1'b1;
			d.clr_cnt = 2'd0;
		end else if (tick && q.clr_busy) begin
			d.clr_busy = !clr_now;
			d.clr_cnt = q.clr_cnt + 2'd1;
		end

		// Counter only moves on watchdog clock edges, so sleep is harmless
		if (debug_halt_i) begin
			d.cnt = 14'h0;
		end else if (q.dbg && win_on) begin
			d.mode = WWD_FIRST;
			d.cnt = 14'h0;
		end else if (tick) begin
			unique case (q.mode)
				WWD_OFF: d.cnt = 14'h0;
				WWD_FIRST, WWD_OPEN: begin
					if (clr_now) begin
						d.mode = win_on ? WWD_CLOSED : WWD_OPEN;
						d.cnt = 14'h0;
					end else if (q.cnt == plen - 14'h1) begin
						d.rst = 1'b1;
						d.mode = start_mode(q.act);
						d.cnt = 14'h0;
					end else begin
						d.cnt = q.cnt + 14'h1;
					end
				end
				WWD_CLOSED: begin
					if (clr_now) begin
						d.rst = 1'b1;
						d.mode = WWD_FIRST;
						d.cnt = 14'h0;
					end else if (q.cnt == wlen - 14'h1) begin
						d.mode = WWD_OPEN;
						d.cnt = 14'h0;
					end else begin
						d.cnt = q.cnt + 14'h1;
					end
				end
			endcase
		end

		// New setting lands after two watchdog clock edges
		// A fresh write restarts the sync instead of being lost to the old one
		if (tick && q.busy && !ctrl_wr) begin
			if (q.sync_cnt == `WWD_SYNC_TICKS - 2'd1) begin
				d.act = q.pend;
				d.busy = 1'b0;
				d.mode = start_mode(q.pend);
				d.cnt = 14'h0;
			end else begin
				d.sync_cnt = q.sync_cnt + 2'd1;
			end
		end
	end

	// ****************************************************************
	// Registers and outputs
	// ****************************************************************

	// Whole state in one register; reset reloads from the fuse
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			q <= init;
		end else begin
			q <= d;
		end
	end

	assign wb_ack_o = q.ack;
	assign wb_dat_o = q.rdata;
	assign sys_reset_req_o = q.rst;

endmodule

// ### dv/wwd_cpu_model.sv
// ****************************************
// CPU side: instruction stream and clears
// ****************************************
module wwd_cpu_model (
	input wire logic mclk_i,
	input wire logic clear_go_i,
	output logic cpu_instr_o,
	output logic clear_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial cpu_instr_o = 1'b0;
	initial clear_o = 1'b0;
	// One instruction every other cycle, so a key and a write stay close
	always @(posedge mclk_i) begin
		cpu_instr_o <= !cpu_instr_o;
		clear_o <= clear_go_i;
	end
endmodule

// ### dv/wwd_watchdog_monitor.sv
module wwd_watchdog_monitor
	import wwd_pkg::*;
(
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic debug_halt_i,
	input wire logic sys_reset_req_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (srst_i);
	// Bus answers come exactly one cycle after a request is taken
	ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	ack_reply_a: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_stb_i))
		else $error("ack without request");
	read_upper_a: assert property (
		wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
		else $error("read upper bits set");
	hidden_read_a: assert property (
		wb_ack_o && !wb_we_i && wb_adr_i[3] |-> wb_dat_o == 32'h0)
		else $error("key or hole reads nonzero");
	status_rsvd_a: assert property (
		wb_ack_o && !wb_we_i && wb_adr_i[3:2] == 2'd1
		|-> wb_dat_o[6:1] == 6'h0)
		else $error("status reserved bits set");
	reset_pulse_a: assert property (
		sys_reset_req_o |=> !sys_reset_req_o)
		else $error("reset request too long");
	debug_quiet_a: assert property (
		debug_halt_i [*3] |-> !sys_reset_req_o)
		else $error("reset during debug halt");
endmodule
bind wwd_watchdog wwd_watchdog_monitor mon (.mclk_i(mclk_i), .srst_i(srst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.debug_halt_i(debug_halt_i), .sys_reset_req_o(sys_reset_req_o));

// ### dv/windowed_watchdog_timer_tb.sv
module windowed_watchdog_timer_tb
	import wwd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk_i = 0, srst_i = 1, cyc = 0, stb = 0, we = 0;
	logic osc = 0, go = 0, dbg = 0, ack, instr, clr, rreq;
	logic [3:0] adr = 0;
	logic [7:0] dat = 0, fuse = 0, got, rst_raw = 0, rst_base = 0, rst_cnt;
	logic [31:0] rdat;
	int err_total = 0, checked = 0, cyc_cnt = 0;
	always #20 mclk_i = ~mclk_i;
	// Resets seen since the last baseline; one driver per counter
	assign rst_cnt = rst_raw - rst_base;
	// Watchdog oscillator sped up to 8 system cycles a tick to keep runs short
	always #160 osc = ~osc;
	wwd_watchdog dut (.mclk_i(mclk_i), .srst_i(srst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
		.wb_dat_i({24'h0, dat}), .wb_dat_o(rdat), .wb_ack_o(ack),
		.watchdog_counter_clock_i(osc), .watchdog_clear_instruction_i(clr),
		.cpu_instr_i(instr), .debug_halt_i(dbg),
		.watchdog_config_fuse_i(fuse), .sys_reset_req_o(rreq));
	wwd_cpu_model cpu (.mclk_i(mclk_i), .clear_go_i(go),
		.cpu_instr_o(instr), .clear_o(clr));
	// ****************************************
	// Tasks
	// ****************************************
	task test_done;
		$display("mismatches %0d comparisons %0d", err_total, checked);
		if (err_total == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task chk(input string n, input logic [7:0] s, input logic [7:0] e);
		checked++;
		if (s !== e) begin
			$display("unexpected %s expected %h seen %h", n, e, s);
			err_total++;
		end
	endtask
	// Request held until ack is sampled; read data taken at that edge
	task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		dat <= d;
		do @(posedge mclk_i); while (ack !== 1'b1);
		got = rdat[7:0];
		cyc <= 0;
		stb <= 0;
	endtask
	task rd(input logic [3:0] a, input logic [7:0] e);
		bus(0, a, 8'h00);
		chk($sformatf("reg %h", a), got, e);
	endtask
	task pwr(input logic [3:0] a, input logic [7:0] d);
		bus(1, 4'h8, 8'h5a);
		bus(1, a, d);
	endtask
	task watchdog_clear_instruction;
		@(posedge mclk_i);
		go <= 1;
		@(posedge mclk_i);
		go <= 0;
	endtask
	task wt(input int n);
		repeat (n * 8) @(posedge mclk_i);
	endtask
	// Reset requests counted; a hang ends in the closing report
	always @(posedge mclk_i) begin
		if (rreq === 1'b1) rst_raw <= rst_raw + 8'h01;
		cyc_cnt++;
		if (cyc_cnt == 8000) begin
			err_total++;
			test_done();
		end
	end
	initial begin
		repeat (16) @(posedge mclk_i);
		srst_i <= 0;
		rd(4'h0, 8'h00);
		rd(4'h4, 8'h00);
		bus(1, 4'hc, 8'hff);
		rd(4'hc, 8'h00);
		bus(1, 4'h0, 8'h01);
		rd(4'h0, 8'h00);
		bus(1, 4'h8, 8'h5a);
		repeat (12) @(posedge mclk_i);
		bus(1, 4'h0, 8'h01);
		rd(4'h0, 8'h00);
		pwr(4'h0, 8'h01);
		rd(4'h4, 8'h01);
		wt(3);
		rd(4'h4, 8'h00);
		rd(4'h0, 8'h01);
		rst_base = rst_raw;
		repeat (4) begin
			watchdog_clear_instruction();
			wt(5);
		end
		chk("resets", rst_cnt, 8'h00);
		wt(9);
		chk("resets", rst_cnt, 8'h01);
		// Double clear: the second must be dropped, else it lands in closed
		pwr(4'h0, 8'h11);
		wt(3);
		rst_base = rst_raw;
		watchdog_clear_instruction();
		watchdog_clear_instruction();
		wt(12);
		watchdog_clear_instruction();
		wt(4);
		chk("resets", rst_cnt, 8'h00);
		watchdog_clear_instruction();
		wt(4);
		chk("resets", rst_cnt, 8'h01);
		dbg <= 1;
		wt(20);
		chk("resets", rst_cnt, 8'h01);
		dbg <= 0;
		wt(3);
		watchdog_clear_instruction();
		wt(4);
		chk("resets", rst_cnt, 8'h01);
		fuse <= 8'h02;
		srst_i <= 1;
		repeat (16) @(posedge mclk_i);
		srst_i <= 0;
		rd(4'h0, 8'h02);
		rd(4'h4, 8'h80);
		pwr(4'h0, 8'h00);
		rd(4'h0, 8'h02);
		pwr(4'h4, 8'h00);
		rd(4'h4, 8'h80);
		dbg <= 1;
		pwr(4'h4, 8'h00);
		rd(4'h4, 8'h00);
		test_done();
	end
endmodule
